// [design/mmsr_meter_regs.sv]
/*
  meter configuration, condition and calibration control register bank.
  assumes apb on pclk; the power sign and line cycle tick come from pins
  of the metering front end in another domain.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "mmsr_regs.svh"

// Contract
// - 16-bit read/write configuration register at offset 0x000 steers the meter.
// - config bits 13-15 volt-amp mode select, stored, no effect.
// - config bits 11-12 real power mode select, stored, no effect.
// - config bits 8-10 and status bits 0,1,3-15 read zero.
// - config bits 6-7 input gain select, stored, no effect.
// - config bits 3-5 enable each phase into totals and pulse output.
// - config bit 2 set accumulates positive energy only, else signed.
// - config bit 1 selects single point phase correction.
// - config bit 0 enables the no-load threshold.
// - status bit 2 reads raw active power sign, one when negative.
// - calib bit 0 mode now; bit 1 runs cycles, cleared by device.
module mmsr_meter_regs
  import mmsr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // metering front end pins
  input  wire logic        raw_power_negative,
  input  wire logic        line_cycle_tick,
  // controls to the energy datapath
  output logic      [2:0]  phase_pulse_enable,
  output logic             positive_only,
  output logic             single_point_correct,
  output logic             no_load_cutoff_enable,
  output logic             calib_mode,
  output logic             calib_accumulate
);

  mmsr_apb_if rb ();

  mmsr_word_t      cfg_q;
  logic [1:0]      cal_q;
  logic [3:0]      exp_q;
  logic [3:0]      exp_live_q;
  logic [7:0]      cnt_q;
  logic [8:0]      run_q;
  mmsr_cal_state_t cal_st_q;
  logic            sign_s;
  logic            tick_s;
  logic            tick_prev_q;
  logic            tick_pulse;
  logic            period_end;
  logic            cal_wr;
  logic            cal_upd_set;
  logic            cal_mode_q;

  // ----------------------------------------
  // bus front end and pin synchronisers
  // ----------------------------------------
  mmsr_apb_slave u_slave (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rb      (rb)
  );

  mmsr_sync u_sign_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (raw_power_negative),
    .dout    (sign_s)
  );

  mmsr_sync u_tick_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (line_cycle_tick),
    .dout    (tick_s)
  );

  // edge taken from the synchronised copy only
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tick_prev_q <= 1'b0;
    else
      tick_prev_q <= tick_s;

  assign tick_pulse = tick_s & ~tick_prev_q;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [8:0] cycles_of(input logic [3:0] e);
    cycles_of = 9'h001 << e;
  endfunction : cycles_of

  assign cal_wr      = rb.wr_stb & hit(rb.addr, `MMSR_OFF_CALIB);
  assign cal_upd_set = cal_wr & rb.wdata[`MMSR_CAL_UPDATE];

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  // reserved mode fields are stored and read back, unused bits never stored
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg_q <= `MMSR_CFG_RESET;
    else if (rb.wr_stb && hit(rb.addr, `MMSR_OFF_CONFIG))
      cfg_q <= rb.wdata & `MMSR_CFG_WR_MASK;

  // ----------------------------------------
  // line cycle exponent and counter
  // ----------------------------------------
  // writes above the largest exponent are clamped
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      exp_q <= `MMSR_EXP_RESET;
    else if (rb.wr_stb && hit(rb.addr, `MMSR_OFF_CYCLE_EXP_B))
      exp_q <= (rb.wdata[15:4] != 12'h000 || rb.wdata[3:0] > `MMSR_EXP_MAX) ?
               `MMSR_EXP_MAX : rb.wdata[3:0];

  // new exponent waits for the running period to finish
  assign period_end = tick_pulse && ({1'b0, cnt_q} == cycles_of(exp_live_q) - 9'h001);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q      <= 8'h00;
      exp_live_q <= `MMSR_EXP_RESET;
    end
    else if (period_end)
    begin
      cnt_q      <= 8'h00;
      exp_live_q <= exp_q;
    end
    else if (tick_pulse)
      cnt_q <= cnt_q + 8'h01;

  // ----------------------------------------
  // calibration control
  // ----------------------------------------
  // mode bit acts at once; update waits for the next line cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cal_mode_q <= 1'b0;
    else if (cal_wr)
      cal_mode_q <= rb.wdata[`MMSR_CAL_MODE];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cal_st_q <= MMSR_CAL_IDLE;
      run_q    <= 9'h000;
    end
    else
      case (cal_st_q)
        MMSR_CAL_IDLE:
          if (cal_upd_set)
            cal_st_q <= MMSR_CAL_ARMED;
        MMSR_CAL_ARMED:
          if (!cal_q[`MMSR_CAL_MODE])
            cal_st_q <= MMSR_CAL_IDLE;
          else if (tick_pulse)
          begin
            cal_st_q <= MMSR_CAL_RUN;
            run_q    <= cycles_of(exp_live_q);
          end
        MMSR_CAL_RUN:
          if (!cal_q[`MMSR_CAL_MODE])
            cal_st_q <= MMSR_CAL_IDLE;
          else if (tick_pulse)
          begin
            run_q <= run_q - 9'h001;
            if (run_q == 9'h001)
              cal_st_q <= cal_upd_set ? MMSR_CAL_ARMED : MMSR_CAL_IDLE;
          end
        default:
          cal_st_q <= MMSR_CAL_IDLE;
      endcase

  // software set beats the device clear in the same cycle
  // one process owns the whole word, so neither bit has two drivers
  always_comb
  begin
    cal_q[`MMSR_CAL_MODE]   = cal_mode_q;
    cal_q[`MMSR_CAL_UPDATE] = (cal_st_q != MMSR_CAL_IDLE);
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // the front end answers writes to read-only and unmapped words with pslverr
  always_comb
  begin
    rb.rdata = 32'h0000_0000;
    rb.err   = 1'b0;
    if (hit(rb.addr, `MMSR_OFF_CONFIG))
      rb.rdata = {16'h0000, cfg_q};
    else if (hit(rb.addr, `MMSR_OFF_CONDITION))
    begin
      rb.rdata[`MMSR_COND_SIGN] = sign_s;
      rb.err = rb.wr_stb;
    end
    else if (hit(rb.addr, `MMSR_OFF_CALIB))
      rb.rdata = {30'h0000_0000, cal_q};
    else if (hit(rb.addr, `MMSR_OFF_CYCLE_EXP_B))
      rb.rdata = {28'h000_0000, exp_q};
    else if (hit(rb.addr, `MMSR_OFF_CYCLE_CNT_B))
    begin
      rb.rdata = {24'h00_0000, cnt_q};
      rb.err = rb.wr_stb;
    end
    else
      rb.err = 1'b1;
  end

  // ----------------------------------------
  // controls to the datapath
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      phase_pulse_enable    <= 3'h0;
      positive_only         <= 1'b0;
      single_point_correct  <= 1'b0;
      no_load_cutoff_enable <= 1'b0;
      calib_mode            <= 1'b0;
      calib_accumulate      <= 1'b0;
    end
    else
    begin
      phase_pulse_enable    <= cfg_q[`MMSR_CFG_PH3_EN:`MMSR_CFG_PH1_EN];
      positive_only         <= cfg_q[`MMSR_CFG_POS_ONLY];
      single_point_correct  <= cfg_q[`MMSR_CFG_SINGLE_PT];
      no_load_cutoff_enable <= cfg_q[`MMSR_CFG_NOLOAD];
      calib_mode            <= cal_q[`MMSR_CAL_MODE];
      // outside calibration the datapath always accumulates
      calib_accumulate      <= ~cal_q[`MMSR_CAL_MODE] | (cal_st_q == MMSR_CAL_RUN);
    end

endmodule : mmsr_meter_regs

// [design/mmsr_regs.svh]
/*
  register offsets, field positions and reset values of the meter mode and
  status register bank.
  assumes byte addressing on a 32-bit apb bus, one register per word.
*/
`ifndef MMSR_REGS_SVH
`define MMSR_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define MMSR_OFF_CONFIG      12'h000
`define MMSR_OFF_CONDITION   12'h004
`define MMSR_OFF_CALIB       12'h008
`define MMSR_OFF_CYCLE_EXP   12'h00A
`define MMSR_OFF_CYCLE_CNT   12'h00C
`define MMSR_OFF_CYCLE_EXP_B 12'h010
`define MMSR_OFF_CYCLE_CNT_B 12'h014

// ----------------------------------------
// meter_config fields
// ----------------------------------------
`define MMSR_CFG_NOLOAD      0
`define MMSR_CFG_SINGLE_PT   1
`define MMSR_CFG_POS_ONLY    2
`define MMSR_CFG_PH1_EN      3
`define MMSR_CFG_PH2_EN      4
`define MMSR_CFG_PH3_EN      5
`define MMSR_CFG_WR_MASK     16'hF8FF
`define MMSR_CFG_RESET       16'h0000

// ----------------------------------------
// meter_condition and calib_ctrl fields
// ----------------------------------------
`define MMSR_COND_SIGN       2
`define MMSR_CAL_MODE        0
`define MMSR_CAL_UPDATE      1
`define MMSR_CAL_RESET       2'h0

// ----------------------------------------
// line cycle exponent
// ----------------------------------------
`define MMSR_EXP_MAX         4'h8
`define MMSR_EXP_RESET       4'h0

`endif

// [design/mmsr_pkg.sv]
/*
  types shared by the meter register bank modules.
  assumes mmsr_regs.svh for all numeric constants.
*/
package mmsr_pkg;

  typedef enum logic [1:0] {
    MMSR_CAL_IDLE,
    MMSR_CAL_ARMED,
    MMSR_CAL_RUN
  } mmsr_cal_state_t;

  typedef logic [15:0] mmsr_word_t;

endpackage : mmsr_pkg

// [design/mmsr_apb_if.sv]
/*
  carrier for one decoded apb register access inside the bank.
  assumes a single pclk domain.
*/
`timescale 1ns/1ps
interface mmsr_apb_if;
  logic        wr_stb;
  logic        rd_stb;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [31:0] rdata;
  logic        err;

  modport slave  (output wr_stb, output rd_stb, output addr, output wdata,
                  input rdata, input err);
  modport target (input wr_stb, input rd_stb, input addr, input wdata,
                  output rdata, output err);
endinterface : mmsr_apb_if

// [design/mmsr_apb_slave.sv]
/*
  apb slave front end: turns the access phase into one-cycle strobes and
  registers the answer so that pready follows one cycle after the strobe.
  assumes a well behaved apb master on pclk.
*/
`timescale 1ns/1ps
module mmsr_apb_slave
  import mmsr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // register side
  mmsr_apb_if.slave        rb
);

  logic busy_q;

  // ----------------------------------------
  // strobes
  // ----------------------------------------
  // one access per transfer; second access cycle only answers
  assign rb.wr_stb = psel & penable & pwrite & ~busy_q;
  assign rb.rd_stb = psel & penable & ~pwrite & ~busy_q;
  assign rb.addr   = paddr;
  assign rb.wdata  = pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      busy_q <= 1'b0;
    else
      busy_q <= psel & penable & ~busy_q;

  // ----------------------------------------
  // answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~busy_q;
      prdata  <= rb.rd_stb ? rb.rdata : 32'h0000_0000;
      pslverr <= (rb.rd_stb | rb.wr_stb) & rb.err;
    end

endmodule : mmsr_apb_slave

// [design/mmsr_sync.sv]
/*
  two flip-flop synchroniser for pin levels.
  assumes the input is a slow level from outside the pclk domain.
*/
`timescale 1ns/1ps
module mmsr_sync
  import mmsr_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end

endmodule : mmsr_sync

// [tb/mmsr_meter_regs_monitor.sv]
/*
  concurrent checks on the ports of the meter register bank.
  assumes one apb access in flight and pready one cycle after access start.
*/
`timescale 1ns/1ps
module mmsr_meter_regs_monitor
  import mmsr_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and controls
  input wire logic        raw_power_negative,
  input wire logic [2:0]  phase_pulse_enable,
  input wire logic        positive_only,
  input wire logic        single_point_correct,
  input wire logic        no_load_cutoff_enable,
  input wire logic        calib_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----
  // helpers
  // ----
  logic       acc1, wr0, wr8, rd0, rd4, raw_q;
  logic [5:0] cfg_q;
  logic       cal_q;
  logic [2:0] stab_q;
  assign acc1 = psel && penable && !pready;
  assign wr0  = acc1 && pwrite && paddr == 12'h000;
  assign wr8  = acc1 && pwrite && paddr == 12'h008;
  assign rd0  = pready && psel && !pwrite && paddr == 12'h000;
  assign rd4  = pready && psel && !pwrite && paddr == 12'h004;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_q <= 6'h00;
      cal_q <= 1'b0;
    end
    else
    begin
      if (wr0) cfg_q <= pwdata[5:0];
      if (wr8) cal_q <= pwdata[0];
    end

  // pin must sit still a while, the sync chain hides fresh edges
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      raw_q  <= 1'b0;
      stab_q <= 3'h0;
    end
    else
    begin
      raw_q  <= raw_power_negative;
      stab_q <= (raw_q != raw_power_negative) ? 3'h0 : (stab_q == 3'h7) ? 3'h7 : stab_q + 3'h1;
    end

  // ----
  // assertions
  // ----
  chk_ready_next: assert property (acc1 |=> pready)
    else $error("pready missing after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  chk_unmapped_err: assert property (acc1 && !(paddr inside {12'h000, 12'h004, 12'h008,
    12'h010, 12'h014}) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_ro_write: assert property (acc1 && pwrite && paddr == 12'h004 |=> pslverr)
    else $error("condition write not refused");
  chk_cfg_reserved: assert property (rd0 |-> prdata[31:16] == 16'h0 && prdata[10:8] == 3'h0)
    else $error("config unused bits not zero");
  chk_cond_reserved: assert property (rd4 |-> prdata[31:3] == 29'h0 && prdata[1:0] == 2'h0)
    else $error("condition unused bits not zero");
  chk_sign_flag: assert property (rd4 && stab_q == 3'h7 |-> prdata[2] == raw_power_negative)
    else $error("sign flag wrong");
  chk_cfg_outputs: assert property (wr0 |-> ##[1:2] {phase_pulse_enable, positive_only,
    single_point_correct, no_load_cutoff_enable} == cfg_q)
    else $error("config controls do not follow write");
  chk_cal_mode: assert property (wr8 |-> ##[1:2] calib_mode == cal_q)
    else $error("calibration mode does not follow write");
endmodule : mmsr_meter_regs_monitor

bind mmsr_meter_regs mmsr_meter_regs_monitor mmsr_meter_regs_monitor_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .raw_power_negative,
  .phase_pulse_enable, .positive_only, .single_point_correct, .no_load_cutoff_enable,
  .calib_mode);

// [tb/meter_mode_status_regs_bench.sv]
/*
  self-checking bench for the meter register bank over apb.
  assumes pready answers within a few cycles and ticks latch in 3 cycles.
*/
`timescale 1ns/1ps
module meter_mode_status_regs_bench
  import mmsr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, d;
  logic        er, raw_power_negative, line_cycle_tick;
  logic [2:0]  phase_pulse_enable;
  logic        positive_only, single_point_correct, no_load_cutoff_enable;
  logic        calib_mode, calib_accumulate;
  integer      seed, i, error_cnt, n_compared;

  mmsr_meter_regs mmsr_meter_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .raw_power_negative, .line_cycle_tick,
    .phase_pulse_enable, .positive_only, .single_point_correct, .no_load_cutoff_enable,
    .calib_mode, .calib_accumulate);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----
  // tasks
  // ----
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  // holds the request until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    integer k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k >= 16)
    begin
      error_cnt++;
      wrap_up;
    end
    rdv = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] wd, input logic ee);
    apb(1'b1, a, wd);
    cmp(er, ee);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    cmp(rdv, e);
    cmp(er, ee);
  endtask : rd

  task tick(input integer n);
    repeat (n)
    begin
      line_cycle_tick <= 1'b1;
      repeat (4) @(posedge pclk);
      line_cycle_tick <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : tick

  function logic [31:0] cfg_exp(input logic [31:0] wd);
    return {16'h0, wd[15:0] & 16'hF8FF};
  endfunction : cfg_exp

  // ----
  // sequence
  // ----
  initial
  begin
    seed = 32'h65A85C12; error_cnt = 0; n_compared = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    raw_power_negative = 0; line_cycle_tick = 0; presetn = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h008, 32'h0, 1'b0);
    rd(12'h004, 32'h0, 1'b0);
    cmp(calib_accumulate, 1'b1);
    for (i = 0; i < 12; i++)
    begin
      d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      wr(12'h000, d, 1'b0);
      repeat (2) @(posedge pclk);
      cmp({phase_pulse_enable, positive_only, single_point_correct, no_load_cutoff_enable},
        d[5:0]);
      rd(12'h000, cfg_exp(d), 1'b0);
      raw_power_negative <= d[8];
      repeat (8) @(posedge pclk);
      rd(12'h004, {29'h0, d[8], 2'h0}, 1'b0);
    end
    wr(12'h004, 32'hFFFF, 1'b1);
    rd(12'h020, 32'h0, 1'b1);
    wr(12'h010, 32'hF, 1'b0);
    rd(12'h010, 32'h8, 1'b0);
    wr(12'h010, 32'h1, 1'b0);
    wr(12'h014, 32'h5, 1'b1);
    tick(2);
    rd(12'h014, 32'h1, 1'b0);
    wr(12'h008, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    cmp({calib_mode, calib_accumulate}, 2'b10);
    wr(12'h008, 32'h3, 1'b0);
    rd(12'h008, 32'h3, 1'b0);
    tick(1);
    cmp(calib_accumulate, 1'b1);
    rd(12'h008, 32'h3, 1'b0);
    tick(4);
    rd(12'h008, 32'h1, 1'b0);
    cmp(calib_accumulate, 1'b0);
    wr(12'h008, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    cmp({calib_mode, calib_accumulate}, 2'b01);
    wr(12'h000, 32'h3F, 1'b0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0, 1'b0);
    wrap_up;
  end
endmodule : meter_mode_status_regs_bench
